/* File: common/kbc_host_pkg.sv */
/*
  Shared constants and types for the keyboard controller host interface:
  host addresses, status and port bit positions, reset values, memory sizes.
  Assumes a single 250 MHz clock domain and an asynchronous active-high reset.
*/
`default_nettype none

package kbc_host_pkg;

  // ----------------------------------------------------------------------
  // Host addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA       = 8'h60;
  localparam logic [7:0] ADDR_CMD        = 8'h64;
  localparam int         ADDR_LINE_TWO   = 2;
  localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int         ST_OUT_FULL     = 0;
  localparam int         ST_IN_FULL      = 1;
  localparam int         ST_CD           = 3;
  localparam logic [7:0] ST_USER_MASK    = 8'hf4;
  localparam logic [7:0] STATUS_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // Controller port 2 bit positions
  // ----------------------------------------------------------------------
  localparam int         P2_A20          = 1;
  localparam int         P2_MOUSE_DATA   = 2;
  localparam int         P2_MOUSE_CLOCK  = 3;
  localparam int         P2_KBD_IRQ      = 4;
  localparam int         P2_MOUSE_IRQ    = 5;
  localparam int         P2_KBD_CLOCK    = 6;
  localparam int         P2_KBD_DATA     = 7;
  // Line bits at one so all four lines are pulled low; irq bits at zero
  localparam logic [7:0] PORT2_RESET     = 8'hcc;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int         ROM_DEPTH       = 2048;
  localparam int         RAM_DEPTH       = 256;
  localparam int         OUT_FIFO_DEPTH  = 8;
  localparam int         RESET_MIN_CLKS  = 24;

  // Power modes, Gray along run -> soft -> hard
  typedef enum logic [1:0]
  {
    PWR_RUN  = 2'b00,
    PWR_SOFT = 2'b01,
    PWR_HARD = 2'b11
  } power_e;

endpackage

`default_nettype wire

/* File: dv/kbc_host_monitor.sv */
/*
  Checker of the host interface flags, interrupts and line enables.
  Assumes one clock domain; bound to the top module below.
*/
`default_nettype none

module kbc_host_monitor (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Host side
  input wire logic       host_cs,
  input wire logic [7:0] host_addr,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic       kbd_interrupt_out,
  input wire logic       mouse_interrupt_out,
  input wire logic       address20_gate,
  // Controller side
  input wire logic       ctl_in_rd,
  input wire logic [7:0] ctl_status,
  input wire logic       ctl_status_wr,
  input wire logic       ctl_out_clear,
  input wire logic [7:0] ctl_port2,
  input wire logic       ctl_enable_flags,
  // Line enables
  input wire logic       kbd_clock_line_oe,
  input wire logic       kbd_data_line_oe,
  input wire logic       mouse_clock_line_oe,
  input wire logic       mouse_data_line_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic gated_r;

  // Gating mirror; only reset turns it off again
  always_ff @(posedge clock or posedge rst)
    if (rst)
      gated_r <= 1'h0;
    else if (ctl_enable_flags)
      gated_r <= 1'h1;

  a_host_write: assert property (host_cs && host_wr && (host_addr == 8'h60 || host_addr == 8'h64)
    |=> ctl_status[1] && ctl_status[3] == $past(host_addr[2]))
    else $error("host write flags wrong");
  a_ctl_read: assert property (ctl_in_rd && !host_wr |=> !ctl_status[1])
    else $error("input flag not cleared");
  a_gated_read: assert property (gated_r && host_cs && host_rd && host_addr == 8'h60
    |=> !ctl_status[0] && !kbd_interrupt_out)
    else $error("data read left output flag");
  a_kbd_irq: assert property ($stable(gated_r) && $stable(ctl_port2) && $stable(ctl_status[0])
    |-> kbd_interrupt_out == (ctl_port2[4] && (ctl_status[0] || !gated_r)))
    else $error("keyboard irq wrong");
  a_mouse_irq: assert property ($stable(gated_r) && $stable(ctl_port2) && $stable(ctl_status[1])
    |-> mouse_interrupt_out == (ctl_port2[5] && !(gated_r && ctl_status[1])))
    else $error("mouse irq wrong");
  a_quiet_status: assert property (host_cs && host_rd && host_addr == 8'h64 && ctl_status[0]
    && !host_wr && !ctl_in_rd && !ctl_status_wr && !ctl_out_clear |=> $stable(ctl_status))
    else $error("status read changed flags");
  a_lines_follow: assert property ({kbd_clock_line_oe, kbd_data_line_oe, mouse_clock_line_oe,
    mouse_data_line_oe, address20_gate} == {ctl_port2[6], ctl_port2[7], ctl_port2[3:1]})
    else $error("port bits not on lines");
  a_reset_state: assert property ($fell(rst) |-> ctl_status == 8'h00 && !kbd_interrupt_out
    && {kbd_clock_line_oe, kbd_data_line_oe, mouse_clock_line_oe, mouse_data_line_oe} == 4'hf)
    else $error("reset state wrong");
endmodule

bind kbc_host_interface kbc_host_monitor mon (.*);

`default_nettype wire

/* File: dv/kbc_line_model.sv */
/*
  Far-side model of the four open-drain keyboard and mouse lines.
  Assumes pull-ups on every line; the bench says which far device pulls low.
*/
`default_nettype none

module kbc_line_model (
  // Block enables, high pulls low
  input  wire logic       kbd_clock_line_oe,
  input  wire logic       kbd_data_line_oe,
  input  wire logic       mouse_clock_line_oe,
  input  wire logic       mouse_data_line_oe,
  // Far pulls: kbd clock, kbd data, mouse clock, mouse data
  input  wire logic [3:0] dev_low,
  // Resolved levels
  output logic            kbd_clock_line_in,
  output logic            kbd_data_line_in,
  output logic            mouse_clock_line_in,
  output logic            mouse_data_line_in
);
  // Wired-AND with pull-ups, so a released line never shows a stale level
  assign kbd_clock_line_in   = !(kbd_clock_line_oe || dev_low[3]);
  assign kbd_data_line_in    = !(kbd_data_line_oe || dev_low[2]);
  assign mouse_clock_line_in = !(mouse_clock_line_oe || dev_low[1]);
  assign mouse_data_line_in  = !(mouse_data_line_oe || dev_low[0]);
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
/*
  Self-checking bench for the keyboard controller host interface.
  Assumes the line model on the far side; inputs move on falling edges.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals
  logic        clock = 1'h0, rst = 1'h1, host_cs = 1'h0, host_wr = 1'h0, host_rd = 1'h0;
  logic [7:0]  host_addr = 8'h00, host_wdata = 8'h00, host_rdata, controller_input_buffer;
  logic        kbd_interrupt_out, mouse_interrupt_out, address20_gate, ctl_out_ready;
  logic        ctl_in_rd = 1'h0, ctl_status_wr = 1'h0, ctl_out_valid = 1'h0, ctl_out_clear = 1'h0;
  logic [7:0]  ctl_status, ctl_status_wdata = 8'h00, ctl_out_data = 8'h00, ctl_port2;
  logic [7:0]  ctl_port2_wdata = 8'h00;
  logic        ctl_port2_wr = 1'h0, ctl_enable_flags = 1'h0, ctl_halt = 1'h0, ctl_stop = 1'h0;
  logic        ctl_in_int_en = 1'h0, ctl_timer_int_en = 1'h0;
  logic        timer_overflow = 1'h0, ctl_timer_ack = 1'h0;
  logic        test_input_zero, test_input_one, port1_bit_zero, port1_bit_one;
  logic        alu_clock_en, osc_enable, resume_call, resume_next, ctl_irq_input, ctl_irq_timer;
  logic        rom_load_we = 1'h0, ram_we = 1'h0;
  logic [10:0] rom_addr = 11'h000;
  logic [7:0]  ram_addr = 8'h00, rom_wdata = 8'h00, ram_wdata = 8'h00, rom_rdata, ram_rdata;
  logic        kbd_clock_line_in, kbd_data_line_in, mouse_clock_line_in, mouse_data_line_in;
  logic        kbd_clock_line_out, kbd_data_line_out, mouse_clock_line_out, mouse_data_line_out;
  logic        kbd_clock_line_oe, kbd_data_line_oe, mouse_clock_line_oe, mouse_data_line_oe;
  logic [3:0]  dev_low = 4'h0;
  logic [1:0]  woke = 2'h0;
  int          miscompares = 0, compares = 0, cyc = 0, n;

  kbc_host_interface #(.FIFO_DEPTH(8)) uut (.*);
  kbc_line_model far_end (.*);

  // Clock, hang guard and wake-pulse catcher
  initial forever #2 clock = ~clock;
  always @(posedge clock)
  begin
    woke |= {resume_call, resume_next};
    if (++cyc == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(negedge clock);
  endtask

  // Strobe held for one edge, then one idle cycle so effects have landed
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
    tick();
  endtask

  task automatic host(input logic [7:0] a, d, input logic w);
    host_addr = a;
    host_wdata = d;
    host_wr = w;
    host_rd = !w;
    pulse(host_cs);
    host_wr = 1'h0;
    host_rd = 1'h0;
  endtask

  // Hold reset 24 cycles, then look at the documented reset state
  task automatic do_reset();
    rst = 1'h1;
    tick(24);
    rst = 1'h0;
    tick(3);
    check("status", ctl_status, 8'h00);
    check("irq power", 8'({kbd_interrupt_out, alu_clock_en, osc_enable}), 8'h03);
    check("sense", 8'({test_input_zero, port1_bit_zero, test_input_one, port1_bit_one}), 8'h00);
  endtask

  task automatic push(input logic [7:0] d);
    ctl_out_data = d;
    pulse(ctl_out_valid);
    tick(3);
  endtask

  initial
  begin
    do_reset();
    $display("test reset done");
    host(8'h60, 8'ha5, 1'h1);
    check("status", ctl_status, 8'h02);
    check("inbuf", controller_input_buffer, 8'ha5);
    host(8'h64, 8'h3c, 1'h1);
    check("status", ctl_status, 8'h0a);
    check("inbuf", controller_input_buffer, 8'h3c);
    pulse(ctl_in_rd);
    check("status", ctl_status, 8'h08);
    host(8'h70, 8'h11, 1'h1);
    host(8'h70, 8'h00, 1'h0);
    check("unmapped", host_rdata, 8'h00);
    check("inbuf", controller_input_buffer, 8'h3c);
    ctl_status_wdata = 8'hff;
    pulse(ctl_status_wr);
    host(8'h64, 8'h00, 1'h0);
    check("status", host_rdata, 8'hfc);
    ctl_status_wdata = 8'h00;
    pulse(ctl_status_wr);
    $display("test host access done");
    ctl_port2_wdata = 8'h32;
    pulse(ctl_port2_wr);
    tick(2);
    check("pins", 8'({kbd_interrupt_out, mouse_interrupt_out, address20_gate, kbd_clock_line_oe,
      mouse_data_line_oe, test_input_zero, kbd_clock_line_out}), 8'h72);
    dev_low = 4'h5;
    tick(3);
    check("sense", 8'({test_input_zero, port1_bit_zero, test_input_one, port1_bit_one}), 8'h0a);
    dev_low = 4'h0;
    ctl_port2_wdata = 8'h00;
    pulse(ctl_port2_wr);
    tick(2);
    check("irqs", 8'({kbd_interrupt_out, mouse_interrupt_out}), 8'h00);
    $display("test ports done");
    ctl_port2_wdata = 8'h30;
    pulse(ctl_port2_wr);
    pulse(ctl_enable_flags);
    tick(2);
    check("irqs", 8'({kbd_interrupt_out, mouse_interrupt_out}), 8'h01);
    push(8'h5a);
    check("irqs", 8'({kbd_interrupt_out, ctl_status[0]}), 8'h03);
    host(8'h64, 8'h00, 1'h0);
    check("status", host_rdata, 8'h09);
    host(8'h60, 8'h00, 1'h0);
    check("data", host_rdata, 8'h5a);
    check("irq out full", 8'({kbd_interrupt_out, ctl_status[0]}), 8'h00);
    host(8'h60, 8'h01, 1'h1);
    check("mouse", 8'(mouse_interrupt_out), 8'h00);
    pulse(ctl_in_rd);
    ctl_port2_wdata = 8'h20;
    pulse(ctl_port2_wr);
    push(8'h77);
    check("forced low", 8'({kbd_interrupt_out, mouse_interrupt_out}), 8'h01);
    pulse(ctl_out_clear);
    check("status", ctl_status, 8'h00);
    ctl_port2_wdata = 8'h30;
    pulse(ctl_port2_wr);
    $display("test gating done");
    n = 0;
    ctl_out_valid = 1'h1;
    while (ctl_out_ready === 1'h1 && n < 20)
    begin
      ctl_out_data = 8'h80 + 8'(n);
      tick();
      n++;
    end
    ctl_out_valid = 1'h0;
    check("accepted", 8'(n), 8'h09);
    for (int i = 0; i < 9; i++)
    begin
      tick(2);
      host(8'h60, 8'h00, 1'h0);
      check("order", host_rdata, 8'h80 + 8'(i));
    end
    $display("test fifo done");
    pulse(ctl_halt);
    check("alu", 8'(alu_clock_en), 8'h00);
    woke = 2'h0;
    host(8'h60, 8'h01, 1'h1);
    check("wake", 8'({alu_clock_en, osc_enable, woke}), 8'h0d);
    ctl_in_int_en = 1'h1;
    tick();
    check("input irq", 8'(ctl_irq_input), 8'h01);
    pulse(ctl_in_rd);
    check("input irq", 8'(ctl_irq_input), 8'h00);
    pulse(ctl_stop);
    check("stop", 8'({alu_clock_en, osc_enable}), 8'h00);
    woke = 2'h0;
    host(8'h64, 8'h02, 1'h1);
    check("wake", 8'({alu_clock_en, osc_enable, woke}), 8'h0e);
    ctl_timer_int_en = 1'h1;
    pulse(timer_overflow);
    check("timer", 8'(ctl_irq_timer), 8'h01);
    pulse(ctl_timer_ack);
    check("timer", 8'(ctl_irq_timer), 8'h00);
    ram_addr = 8'hff;
    ram_wdata = 8'h3c;
    rom_addr = 11'h7ff;
    rom_wdata = 8'hc3;
    rom_load_we = 1'h1;
    pulse(ram_we);
    rom_load_we = 1'h0;
    check("rom ram", rom_rdata ^ ram_rdata, 8'hff);
    $display("test power done");
    do_reset();
    $display("test second reset done");
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: rtl/kbc_host_interface.sv */
/*
  Host interface of the embedded keyboard controller: host data/command and
  status access, flag gating onto keyboard and mouse interrupts, open-drain
  keyboard/mouse lines, power-down control, controller memories, and an
  output byte FIFO. Assumes synchronous inputs on one clock, open-drain lines
  resolved outside from the enables, and reset held at least 24 clocks.
*/
// What this block does
// - Data write loads buffer, clears C/D, sets input-full
// - Command write loads buffer, sets C/D, input-full
// - Gated data read clears output-full and keyboard irq
// - Controller output write sets output-full
// - Host write copies address line two to C/D
// - Gated keyboard irq follows output-full when enabled
// - Ungated keyboard irq follows its port bit
// - Gated mouse irq carries inverted input-full
// - Ungated mouse irq follows its port bit
// - Port bit drives address-20 gate output
// - Four port bits inverted onto open-drain lines
// - Line levels readable on test and port inputs
// - Halt enters soft power-down, timer stays alive
// - Host write or reset ends soft power-down
// - Stop halts oscillator; same exits apply
// - Only input-full and timer overflow interrupts
// - 2K program ROM, 256 byte data RAM
// - Status cleared on reset, user bits controller-writable
// - Controller input read clears input-full and request
// - Reset drives all lines low, status 00
`default_nettype none

// --------------------------------------------------------------------------
// Output byte FIFO
// --------------------------------------------------------------------------
module kbc_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic  push;
  logic  pop;

  // Pointer step with wrap, for depths that are not powers of two
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest flags straight from the count
  assign in_ready  = (s_r.count != CW'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign out_data  = s_r.mem[s_r.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wr_ptr] = in_data;
      s_nxt.wr_ptr          = ptr_inc(s_r.wr_ptr);
    end
    if (pop)
    begin
      s_nxt.rd_ptr = ptr_inc(s_r.rd_ptr);
    end
    if (push && !pop)
    begin
      s_nxt.count = s_r.count + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule

// --------------------------------------------------------------------------
// Host interface top
// --------------------------------------------------------------------------
module kbc_host_interface #(
  parameter int ROM_DEPTH  = kbc_host_pkg::ROM_DEPTH,
  parameter int RAM_DEPTH  = kbc_host_pkg::RAM_DEPTH,
  parameter int FIFO_DEPTH = kbc_host_pkg::OUT_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Host I/O port
  input  wire logic                         host_cs,
  input  wire logic [7:0]                   host_addr,
  input  wire logic                         host_wr,
  input  wire logic                         host_rd,
  input  wire logic [7:0]                   host_wdata,
  output logic      [7:0]                   host_rdata,
  // Host interrupts and gate
  output logic                              kbd_interrupt_out,
  output logic                              mouse_interrupt_out,
  output logic                              address20_gate,
  // Controller: input buffer and status
  input  wire logic                         ctl_in_rd,
  output logic      [7:0]                   controller_input_buffer,
  output logic      [7:0]                   ctl_status,
  input  wire logic                         ctl_status_wr,
  input  wire logic [7:0]                   ctl_status_wdata,
  // Controller: output bytes
  input  wire logic                         ctl_out_valid,
  output logic                              ctl_out_ready,
  input  wire logic [7:0]                   ctl_out_data,
  input  wire logic                         ctl_out_clear,
  // Controller: port 2 and flag gating
  input  wire logic                         ctl_port2_wr,
  input  wire logic [7:0]                   ctl_port2_wdata,
  output logic      [7:0]                   ctl_port2,
  input  wire logic                         ctl_enable_flags,
  // Controller: line sensing
  output logic                              test_input_zero,
  output logic                              test_input_one,
  output logic                              port1_bit_zero,
  output logic                              port1_bit_one,
  // Controller: power and interrupts
  input  wire logic                         ctl_halt,
  input  wire logic                         ctl_stop,
  input  wire logic                         ctl_in_int_en,
  input  wire logic                         ctl_timer_int_en,
  input  wire logic                         timer_overflow,
  input  wire logic                         ctl_timer_ack,
  output logic                              alu_clock_en,
  output logic                              osc_enable,
  output logic                              resume_call,
  output logic                              resume_next,
  output logic                              ctl_irq_input,
  output logic                              ctl_irq_timer,
  // Controller memories
  input  wire logic                         rom_load_we,
  input  wire logic [$clog2(ROM_DEPTH)-1:0] rom_addr,
  input  wire logic [7:0]                   rom_wdata,
  output logic      [7:0]                   rom_rdata,
  input  wire logic                         ram_we,
  input  wire logic [$clog2(RAM_DEPTH)-1:0] ram_addr,
  input  wire logic [7:0]                   ram_wdata,
  output logic      [7:0]                   ram_rdata,
  // Open-drain keyboard and mouse lines
  input  wire logic                         kbd_clock_line_in,
  output logic                              kbd_clock_line_out,
  output logic                              kbd_clock_line_oe,
  input  wire logic                         kbd_data_line_in,
  output logic                              kbd_data_line_out,
  output logic                              kbd_data_line_oe,
  input  wire logic                         mouse_clock_line_in,
  output logic                              mouse_clock_line_out,
  output logic                              mouse_clock_line_oe,
  input  wire logic                         mouse_data_line_in,
  output logic                              mouse_data_line_out,
  output logic                              mouse_data_line_oe
);

  typedef struct packed {
    kbc_host_pkg::power_e pwr;
    logic                 gating;
    logic [7:0]           status;
    logic [7:0]           in_data;
    logic [7:0]           out_data;
    logic [7:0]           port2;
    logic [7:0]           rdata;
    logic                 timer_pend;
    logic                 kbd_irq;
    logic                 mouse_irq;
    logic [3:0]           sensed;
    logic                 res_call;
    logic                 res_next;
  } hif_s;

  hif_s       s_r;
  hif_s       s_nxt;
  logic [7:0] rom_mem [ROM_DEPTH];
  logic [7:0] ram_mem [RAM_DEPTH];
  logic [7:0] rom_q_r;
  logic [7:0] ram_q_r;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_take;
  logic       wr_data;
  logic       wr_cmd;
  logic       rd_data;
  logic       rd_stat;
  logic       host_write;

  // Address decode shared by read and write
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  assign wr_data    = host_cs & host_wr & addr_is(host_addr, kbc_host_pkg::ADDR_DATA);
  assign wr_cmd     = host_cs & host_wr & addr_is(host_addr, kbc_host_pkg::ADDR_CMD);
  assign rd_data    = host_cs & host_rd & addr_is(host_addr, kbc_host_pkg::ADDR_DATA);
  assign rd_stat    = host_cs & host_rd & addr_is(host_addr, kbc_host_pkg::ADDR_CMD);
  assign host_write = wr_data | wr_cmd;
  // Drain only into an empty output register, so the FIFO backs up
  assign fifo_take  = fifo_valid & ~s_r.status[kbc_host_pkg::ST_OUT_FULL];

  // Output bytes queue here until output-full clears, by a gated host data read or a firmware clear
  kbc_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (ctl_out_valid),
    .in_ready  (ctl_out_ready),
    .in_data   (ctl_out_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  // Next state of the host interface
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.res_call = 1'b0;
    s_nxt.res_next = 1'b0;
    // Pins taken as synchronous, one flop for a clean controller view
    s_nxt.sensed   = {mouse_data_line_in, mouse_clock_line_in,
                      kbd_data_line_in, kbd_clock_line_in};
    if (ctl_enable_flags)
    begin
      s_nxt.gating = 1'b1;
    end
    if (ctl_port2_wr)
    begin
      s_nxt.port2 = ctl_port2_wdata;
    end
    // Controller writes only touch the user-defined status bits
    if (ctl_status_wr)
    begin
      s_nxt.status = (s_r.status & ~kbc_host_pkg::ST_USER_MASK)
                   | (ctl_status_wdata & kbc_host_pkg::ST_USER_MASK);
    end
    // Host reads; a status read leaves every flag alone
    if (rd_stat)
    begin
      s_nxt.rdata = s_r.status;
    end
    else if (rd_data)
    begin
      s_nxt.rdata = s_r.out_data;
      if (s_r.gating)
      begin
        s_nxt.status[kbc_host_pkg::ST_OUT_FULL] = 1'b0;
      end
    end
    else if (host_cs && host_rd)
    begin
      s_nxt.rdata = kbc_host_pkg::UNMAPPED_RDATA;
    end
    // Firmware clear for the ungated case
    if (ctl_out_clear)
    begin
      s_nxt.status[kbc_host_pkg::ST_OUT_FULL] = 1'b0;
    end
    // Output byte load placed after the clears so a set wins
    if (fifo_take)
    begin
      s_nxt.out_data                     = fifo_data;
      s_nxt.status[kbc_host_pkg::ST_OUT_FULL] = 1'b1;
    end
    // Controller input read; a same-cycle host write wins below
    if (ctl_in_rd)
    begin
      s_nxt.status[kbc_host_pkg::ST_IN_FULL] = 1'b0;
    end
    if (host_write)
    begin
      s_nxt.in_data                      = host_wdata;
      s_nxt.status[kbc_host_pkg::ST_IN_FULL] = 1'b1;
      s_nxt.status[kbc_host_pkg::ST_CD]  = host_addr[kbc_host_pkg::ADDR_LINE_TWO];
    end
    // Timer overflow pends until acknowledged; new overflow wins
    if (ctl_timer_ack)
    begin
      s_nxt.timer_pend = 1'b0;
    end
    if (timer_overflow)
    begin
      s_nxt.timer_pend = 1'b1;
    end
    // Power modes
    unique case (s_r.pwr)
      kbc_host_pkg::PWR_RUN:
      begin
        if (ctl_stop)
        begin
          s_nxt.pwr = kbc_host_pkg::PWR_HARD;
        end
        else if (ctl_halt)
        begin
          s_nxt.pwr = kbc_host_pkg::PWR_SOFT;
        end
      end
      kbc_host_pkg::PWR_SOFT,
      kbc_host_pkg::PWR_HARD:
      begin
        if (host_write)
        begin
          s_nxt.pwr      = kbc_host_pkg::PWR_RUN;
          s_nxt.res_call = ctl_in_int_en;
          s_nxt.res_next = ~ctl_in_int_en;
        end
      end
      default:
      begin
        s_nxt.pwr = kbc_host_pkg::PWR_RUN;
      end
    endcase
    // Interrupt outputs registered from the settled flags
    if (s_nxt.gating)
    begin
      s_nxt.kbd_irq   = s_nxt.port2[kbc_host_pkg::P2_KBD_IRQ]
                      & s_nxt.status[kbc_host_pkg::ST_OUT_FULL];
      s_nxt.mouse_irq = s_nxt.port2[kbc_host_pkg::P2_MOUSE_IRQ]
                      & ~s_nxt.status[kbc_host_pkg::ST_IN_FULL];
    end
    else
    begin
      s_nxt.kbd_irq   = s_nxt.port2[kbc_host_pkg::P2_KBD_IRQ];
      s_nxt.mouse_irq = s_nxt.port2[kbc_host_pkg::P2_MOUSE_IRQ];
    end
  end

  // State register; reset leaves lines low, status and irqs clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r        <= '0;
      s_r.pwr    <= kbc_host_pkg::PWR_RUN;
      s_r.status <= kbc_host_pkg::STATUS_RESET;
      s_r.port2  <= kbc_host_pkg::PORT2_RESET;
      s_r.kbd_irq <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Controller memories; contents survive reset, reads take one cycle
  always_ff @(posedge clock)
  begin
    if (rom_load_we)
    begin
      rom_mem[rom_addr] <= rom_wdata;
    end
    if (ram_we)
    begin
      ram_mem[ram_addr] <= ram_wdata;
    end
    rom_q_r <= rom_mem[rom_addr];
    ram_q_r <= ram_mem[ram_addr];
  end

  // Host and controller side outputs
  assign host_rdata              = s_r.rdata;
  assign kbd_interrupt_out       = s_r.kbd_irq;
  assign mouse_interrupt_out     = s_r.mouse_irq;
  assign address20_gate          = s_r.port2[kbc_host_pkg::P2_A20];
  assign controller_input_buffer = s_r.in_data;
  assign ctl_status              = s_r.status;
  assign ctl_port2               = s_r.port2;
  assign rom_rdata               = rom_q_r;
  assign ram_rdata               = ram_q_r;

  // Sensed line levels toward the controller
  assign test_input_zero         = s_r.sensed[0];
  assign port1_bit_zero          = s_r.sensed[1];
  assign test_input_one          = s_r.sensed[2];
  assign port1_bit_one           = s_r.sensed[3];

  // Power and controller interrupts; only two sources exist
  assign alu_clock_en            = (s_r.pwr == kbc_host_pkg::PWR_RUN);
  assign osc_enable              = (s_r.pwr != kbc_host_pkg::PWR_HARD);
  assign resume_call             = s_r.res_call;
  assign resume_next             = s_r.res_next;
  assign ctl_irq_input           = s_r.status[kbc_host_pkg::ST_IN_FULL] & ctl_in_int_en;
  assign ctl_irq_timer           = s_r.timer_pend & ctl_timer_int_en;

  // Inverted port bits: a one pulls the line low, a zero releases it
  assign kbd_clock_line_out      = 1'b0;
  assign kbd_data_line_out       = 1'b0;
  assign mouse_clock_line_out    = 1'b0;
  assign mouse_data_line_out     = 1'b0;
  assign kbd_clock_line_oe       = s_r.port2[kbc_host_pkg::P2_KBD_CLOCK];
  assign kbd_data_line_oe        = s_r.port2[kbc_host_pkg::P2_KBD_DATA];
  assign mouse_clock_line_oe     = s_r.port2[kbc_host_pkg::P2_MOUSE_CLOCK];
  assign mouse_data_line_oe      = s_r.port2[kbc_host_pkg::P2_MOUSE_DATA];

endmodule

`default_nettype wire
